// File: ais_analog_input.sv
`timescale 1ns/1ps
// Overview of operation
// - each channel has a read-only signed 32-bit entry with its current scaled value.
// - a read-only 8-bit entry reports two analog channels.
// - the channel offset is added to the raw sample first, then the sum is divided.
// - the user units come only from the channel offset and divisor settings.
// - with default offset and divisor the value equals the raw converter digits.
// - each channel has a read/write signed offset cleared at reset, plus a read-only count.
// - each channel has a read/write divisor defaulting to one, and zero writes are refused.
module ais_analog_input
    import ais_pkg::*;
(
    // clock and reset
    input  wire logic                              i_core_clk,
    input  wire logic                              i_rst,
    // converter samples
    input  wire logic [ais_pkg::AIS_NUM_CH-1:0]    i_smp_valid,
    input  wire logic [ais_pkg::AIS_RAW_W-1:0]     i_smp_raw_ch1,
    input  wire logic [ais_pkg::AIS_RAW_W-1:0]     i_smp_raw_ch2,
    // object dictionary access
    input  wire logic                              i_obj_rd,
    input  wire logic                              i_obj_wr,
    input  wire logic [15:0]                       i_obj_index,
    input  wire logic [7:0]                        i_obj_sub,
    input  wire logic [31:0]                       i_obj_wdata,
    output logic                                   o_obj_ack,
    output logic                                   o_obj_err,
    output logic [31:0]                            o_obj_rdata
);
    import ais_pkg::*;

    logic [31:0]           value_q  [AIS_NUM_CH];
    logic [31:0]           offset_q [AIS_NUM_CH];
    logic [31:0]           div_q    [AIS_NUM_CH];
    logic [AIS_RAW_W-1:0]  raw_q    [AIS_NUM_CH];
    logic [AIS_NUM_CH-1:0] pend_q;
    logic                  ack_q;
    logic                  err_q;
    logic [31:0]           rdata_q;

    ais_scale_if sif [AIS_NUM_CH] ();

    // ------------------------------------------------------------
    // one scaler per channel
    // ------------------------------------------------------------
    wire logic [AIS_RAW_W-1:0] smp_raw [AIS_NUM_CH];
    assign smp_raw[0] = i_smp_raw_ch1;
    assign smp_raw[1] = i_smp_raw_ch2;

    wire logic [AIS_NUM_CH-1:0] start;
    wire logic [AIS_NUM_CH-1:0] done;
    wire logic [31:0]           result [AIS_NUM_CH];

    for (genvar c = 0; c < AIS_NUM_CH; c++) begin : g_ch
        // a sample arriving mid-job is kept and scaled next, latest wins
        assign start[c]       = pend_q[c] && !sif[c].busy;
        assign sif[c].start   = start[c];
        assign sif[c].raw     = raw_q[c];
        assign sif[c].offset  = offset_q[c];
        assign sif[c].divisor = div_q[c];
        assign done[c]        = sif[c].done;
        assign result[c]      = sif[c].result;

        ais_ch_scaler u_scaler (
            .i_core_clk (i_core_clk),
            .i_rst      (i_rst),
            .sif        (sif[c])
        );

        always_ff @(posedge i_core_clk) begin
            if (i_rst) begin
                pend_q[c]  <= 1'b0;
                raw_q[c]   <= '0;
                value_q[c] <= AIS_VALUE_RST;
            end else begin
                if (i_smp_valid[c]) begin
                    raw_q[c] <= smp_raw[c];
                end
                // new sample wins over the start that consumes the old one
                pend_q[c] <= i_smp_valid[c] || (pend_q[c] && !start[c]);
                if (done[c]) begin
                    value_q[c] <= result[c];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // object decode
    // ------------------------------------------------------------
    wire logic       is_value  = (i_obj_index == AIS_OBJ_VALUE);
    wire logic       is_offset = (i_obj_index == AIS_OBJ_OFFSET);
    wire logic       is_div    = (i_obj_index == AIS_OBJ_DIVISOR);
    wire logic       is_obj    = is_value || is_offset || is_div;
    wire logic       sub_cnt   = (i_obj_sub == AIS_SUB_COUNT);
    wire logic       sub_ch    = (i_obj_sub == AIS_SUB_CH1) || (i_obj_sub == AIS_SUB_CH2);
    wire logic       ch_sel    = (i_obj_sub == AIS_SUB_CH2);
    wire logic       mapped    = is_obj && (sub_cnt || sub_ch);
    wire logic       wr_off    = i_obj_wr && is_offset && sub_ch;
    wire logic       div_zero  = (i_obj_wdata == 32'h0000_0000);
    wire logic       wr_div    = i_obj_wr && is_div && sub_ch && !div_zero;
    wire logic       wr_bad    = i_obj_wr && !(wr_off || wr_div);
    wire logic       rd_bad    = i_obj_rd && !i_obj_wr && !mapped;
    // all three objects report the same channel count at subindex zero
    wire logic [31:0] rd_ch    = is_value  ? value_q[ch_sel] :
                                 is_offset ? offset_q[ch_sel] : div_q[ch_sel];
    wire logic [31:0] rd_mux   = !mapped ? 32'h0000_0000 :
                                 sub_cnt ? {24'h000000, AIS_CH_COUNT_RST} : rd_ch;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            offset_q <= '{default: AIS_OFFSET_RST};
            div_q    <= '{default: AIS_DIVISOR_RST};
        end else begin
            if (wr_off) begin
                offset_q[ch_sel] <= i_obj_wdata;
            end
            if (wr_div) begin
                div_q[ch_sel] <= i_obj_wdata;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= i_obj_rd || i_obj_wr;
            err_q   <= wr_bad || rd_bad;
            rdata_q <= (i_obj_rd && !i_obj_wr) ? rd_mux : 32'h0000_0000;
        end
    end

    assign o_obj_ack   = ack_q;
    assign o_obj_err   = err_q;
    assign o_obj_rdata = rdata_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    chk_ack_follows: assert property ((i_obj_rd || i_obj_wr) |=> o_obj_ack)
        else $error("object access not acknowledged next cycle");
    chk_count_read: assert property ((i_obj_rd && !i_obj_wr && is_obj && sub_cnt)
        |=> o_obj_rdata == 32'h0000_0002 && !o_obj_err)
        else $error("channel count read wrong");
    chk_zero_reject: assert property ((i_obj_wr && is_div && sub_ch && div_zero)
        |=> o_obj_err && div_q[$past(ch_sel)] == $past(div_q[ch_sel]))
        else $error("zero divisor was not refused");
    chk_offset_store: assert property (wr_off |=> offset_q[$past(ch_sel)] ==
        $past(i_obj_wdata) && !o_obj_err)
        else $error("offset write not stored");
    chk_value_update: assert property (done[0] |=> value_q[0] == $past(result[0]))
        else $error("channel value not updated from scaler");
    chk_value_ro: assert property ((i_obj_wr && is_value) |=> o_obj_err)
        else $error("write to read-only value accepted");
endmodule

// File: ais_pkg.sv
package ais_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int          AIS_NUM_CH       = 2;
    localparam int          AIS_RAW_W        = 10;
    localparam logic [5:0]  AIS_DIV_STEPS    = 6'h21;
    // ------------------------------------------------------------
    // object dictionary addresses
    // ------------------------------------------------------------
    localparam logic [15:0] AIS_OBJ_VALUE    = 16'h3320;
    localparam logic [15:0] AIS_OBJ_OFFSET   = 16'h3321;
    localparam logic [15:0] AIS_OBJ_DIVISOR  = 16'h3322;
    localparam logic [7:0]  AIS_SUB_COUNT    = 8'h00;
    localparam logic [7:0]  AIS_SUB_CH1      = 8'h01;
    localparam logic [7:0]  AIS_SUB_CH2      = 8'h02;
    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [7:0]  AIS_CH_COUNT_RST = 8'h02;
    localparam logic [31:0] AIS_VALUE_RST    = 32'h0000_0000;
    localparam logic [31:0] AIS_OFFSET_RST   = 32'h0000_0000;
    localparam logic [31:0] AIS_DIVISOR_RST  = 32'h0000_0001;
    localparam logic [31:0] AIS_INT_MAX      = 32'h7fff_ffff;
    localparam logic [31:0] AIS_INT_MIN      = 32'h8000_0000;

    typedef enum logic [1:0] {
        AIS_IDLE,
        AIS_RUN,
        AIS_FIN
    } ais_div_state_t;
endpackage

// File: ais_scale_if.sv
`timescale 1ns/1ps
interface ais_scale_if;
    logic        start;
    logic [9:0]  raw;
    logic [31:0] offset;
    logic [31:0] divisor;
    logic        busy;
    logic        done;
    logic [31:0] result;

    modport ctrl (output start, raw, offset, divisor, input busy, done, result);
    modport core (input start, raw, offset, divisor, output busy, done, result);
endinterface

// File: ais_ch_scaler.sv
`timescale 1ns/1ps
module ais_ch_scaler
    import ais_pkg::*;
(
    // clock and reset
    input  wire logic   i_core_clk,
    input  wire logic   i_rst,
    // job and result
    ais_scale_if.core   sif
);
    import ais_pkg::*;

    ais_div_state_t state_q;
    logic [32:0]    sum_q;
    logic [31:0]    den_q;
    logic           neg_q;
    logic [32:0]    quo_q;
    logic [32:0]    rem_q;
    logic [5:0]     cnt_q;
    logic           done_q;
    logic [31:0]    result_q;
    logic [31:0]    div_q;

    // ------------------------------------------------------------
    // offset first, then magnitudes for the unsigned divider
    // ------------------------------------------------------------
    wire logic [32:0] raw_ext  = {23'h000000, sif.raw};
    wire logic [32:0] off_ext  = {sif.offset[31], sif.offset};
    wire logic [32:0] sum      = raw_ext + off_ext;
    wire logic [32:0] sum_mag  = sum[32] ? 33'(-sum) : sum;
    wire logic [31:0] den_mag  = sif.divisor[31] ? 32'(-sif.divisor) : sif.divisor;
    wire logic [32:0] trial    = {rem_q[31:0], quo_q[32]};
    wire logic        fits     = trial >= {1'b0, den_q};
    wire logic [32:0] rem_next = fits ? 33'(trial - {1'b0, den_q}) : trial;
    // truncation toward zero falls out of dividing magnitudes
    wire logic        pos_sat  = !neg_q && (quo_q > {1'b0, AIS_INT_MAX});
    wire logic        neg_sat  = neg_q && (quo_q > {1'b0, AIS_INT_MIN});
    wire logic [31:0] signed_q = neg_q ? 32'(-quo_q) : quo_q[31:0];
    wire logic [31:0] final_q  = pos_sat ? AIS_INT_MAX : (neg_sat ? AIS_INT_MIN : signed_q);

    assign sif.busy   = (state_q != AIS_IDLE);
    assign sif.done   = done_q;
    assign sif.result = result_q;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_q  <= AIS_IDLE;
            done_q   <= 1'b0;
            result_q <= AIS_VALUE_RST;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                AIS_IDLE: if (sif.start) state_q <= AIS_RUN;
                AIS_RUN:  if (cnt_q == AIS_DIV_STEPS - 6'h01) state_q <= AIS_FIN;
                AIS_FIN: begin
                    result_q <= final_q;
                    done_q   <= 1'b1;
                    state_q  <= AIS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (state_q == AIS_IDLE && sif.start) begin
            sum_q <= sum;
            div_q <= sif.divisor;
            neg_q <= sum[32] ^ sif.divisor[31];
            den_q <= den_mag;
            quo_q <= sum_mag;
            rem_q <= 33'h0;
            cnt_q <= 6'h00;
        end else if (state_q == AIS_RUN) begin
            rem_q <= rem_next;
            quo_q <= {quo_q[31:0], fits};
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    wire logic signed [33:0] exp_q = $signed({sum_q[32], sum_q}) / $signed({{2{div_q[31]}}, div_q});
    wire logic [31:0] exp_sat = (exp_q > $signed({2'b00, AIS_INT_MAX})) ? AIS_INT_MAX :
                                (exp_q < $signed({2'b11, AIS_INT_MIN})) ? AIS_INT_MIN :
                                exp_q[31:0];

    sequence job_taken;
        state_q == AIS_IDLE && sif.start;
    endsequence

    chk_result_exact: assert property (done_q |-> result_q == exp_sat)
        else $error("scaled result differs from truncated saturated quotient");
    chk_job_latency: assert property (job_taken |-> ##[34:36] done_q)
        else $error("scaling job did not finish in time");
    chk_busy_hold: assert property (job_taken |=> sif.busy [*8])
        else $error("scaler dropped busy during a job");
    chk_default_raw: assert property ((job_taken and (sif.offset == AIS_OFFSET_RST &&
        sif.divisor == AIS_DIVISOR_RST)) |-> ##[34:36] (done_q && result_q ==
        {22'h000000, $past(sif.raw, 35)}))
        else $error("default settings did not pass raw digits through");
endmodule

// File: ais_adc_model.sv
`timescale 1ns/1ps
module ais_adc_model
    import ais_pkg::*;
(
    // clock
    input  wire logic                          i_core_clk,
    // samples toward the readout
    output logic [ais_pkg::AIS_NUM_CH-1:0]     o_valid,
    output logic [ais_pkg::AIS_RAW_W-1:0]      o_raw_ch1,
    output logic [ais_pkg::AIS_RAW_W-1:0]      o_raw_ch2
);
    import ais_pkg::*;

    initial begin
        o_valid   = '0;
        o_raw_ch1 = 10'h155;
        o_raw_ch2 = 10'h2aa;
    end

    // one-cycle sample pulse; called just after a rising edge
    task automatic send(input int ch, input logic [AIS_RAW_W-1:0] raw);
        if (ch == 1) begin
            o_raw_ch1 = raw;
        end else begin
            o_raw_ch2 = raw;
        end
        o_valid[ch-1] = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_valid   = '0;
        // raw means nothing without valid, so never leave a stale copy
        o_raw_ch1 = ~o_raw_ch1;
        o_raw_ch2 = ~o_raw_ch2;
    endtask
endmodule

// File: ais_analog_input_tb.sv
`timescale 1ns/1ps
module ais_analog_input_tb;
    import ais_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                  i_core_clk = 1'b0;
    logic                  i_rst      = 1'b1;
    logic [1:0]            i_smp_valid;
    logic [9:0]            i_smp_raw_ch1;
    logic [9:0]            i_smp_raw_ch2;
    logic                  i_obj_rd   = 1'b0;
    logic                  i_obj_wr   = 1'b0;
    logic [15:0]           i_obj_index = 16'h0;
    logic [7:0]            i_obj_sub  = 8'h0;
    logic [31:0]           i_obj_wdata = 32'h0;
    logic                  o_obj_ack;
    logic                  o_obj_err;
    logic [31:0]           o_obj_rdata;
    logic [32:0]           exp_q[$];
    int                    err_count = 0;
    int                    cmp_count = 0;

    always #5 i_core_clk = ~i_core_clk;

    ais_adc_model ais_adc_model_inst (.i_core_clk(i_core_clk), .o_valid(i_smp_valid),
        .o_raw_ch1(i_smp_raw_ch1), .o_raw_ch2(i_smp_raw_ch2));

    ais_analog_input ais_analog_input_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_smp_valid(i_smp_valid), .i_smp_raw_ch1(i_smp_raw_ch1),
        .i_smp_raw_ch2(i_smp_raw_ch2), .i_obj_rd(i_obj_rd), .i_obj_wr(i_obj_wr),
        .i_obj_index(i_obj_index), .i_obj_sub(i_obj_sub), .i_obj_wdata(i_obj_wdata),
        .o_obj_ack(o_obj_ack), .o_obj_err(o_obj_err), .o_obj_rdata(o_obj_rdata));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic close_out;
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_obj(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // strobe is held between back-to-back calls; idle drops it
    task automatic req(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] wd, input logic [32:0] exp);
        i_obj_rd    = ~wr;
        i_obj_wr    = wr;
        i_obj_index = idx;
        i_obj_sub   = sub;
        i_obj_wdata = wd;
        exp_q.push_back(exp);
        @(posedge i_core_clk);
        #1;
    endtask

    task automatic idle(input int n);
        i_obj_rd = 1'b0;
        i_obj_wr = 1'b0;
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    function automatic logic [31:0] scale(input logic [9:0] raw, input logic [31:0] off,
                                          input logic [31:0] dv);
        longint s;
        s = longint'(raw) + longint'($signed(off));
        s = s / longint'($signed(dv));
        if (s > 64'sh7fff_ffff) s = 64'sh7fff_ffff;
        if (s < -64'sh8000_0000) s = -64'sh8000_0000;
        return s[31:0];
    endfunction

    // an answer must sit in the cycle after its request
    always @(posedge i_core_clk) begin
        if (o_obj_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp_obj({o_obj_err, o_obj_rdata}, ~{o_obj_err, o_obj_rdata});
            end else begin
                cmp_obj({o_obj_err, o_obj_rdata}, exp_q.pop_front());
            end
        end
    end

    initial begin
        #20000;
        err_count++;
        close_out();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    // entry 2 drives the quotient below the signed range, entry 3 above it
    // last two: voltage and current channel read in whole units, ~51 digits a unit
    logic [31:0] offs[6] = '{32'h0, 32'hffff_fda8, 32'h7fff_ffff, 32'h8000_0000,
                             32'hffff_fe00, 32'h0};
    logic [31:0] divs[6] = '{32'h1, 32'hffff_fff9, 32'hffff_ffff, 32'hffff_ffff,
                             32'h33, 32'h33};
    initial begin
        logic [9:0]  raw;
        logic [15:0] idx;
        int          ch;
        void'($urandom(32'h6bd345ee));
        repeat (2) @(posedge i_core_clk);
        #1;
        i_rst = 1'b0;
        for (int o = 0; o < 3; o++) begin
            idx = AIS_OBJ_VALUE + 16'(o);
            req(1'b0, idx, AIS_SUB_COUNT, 32'h0, {1'b0, 32'h2});
            req(1'b0, idx, AIS_SUB_CH1, 32'h0, {1'b0, 32'(o == 2)});
            req(1'b0, idx, AIS_SUB_CH2, 32'h0, {1'b0, 32'(o == 2)});
        end
        req(1'b1, AIS_OBJ_VALUE, AIS_SUB_CH1, 32'h5, {1'b1, 32'h0});
        req(1'b1, AIS_OBJ_OFFSET, AIS_SUB_COUNT, 32'h5, {1'b1, 32'h0});
        req(1'b1, AIS_OBJ_DIVISOR, AIS_SUB_CH1, 32'h0, {1'b1, 32'h0});
        req(1'b0, 16'h3323, AIS_SUB_CH1, 32'h0, {1'b1, 32'h0});
        req(1'b0, AIS_OBJ_VALUE, 8'h03, 32'h0, {1'b1, 32'h0});
        req(1'b0, AIS_OBJ_DIVISOR, AIS_SUB_CH1, 32'h0, {1'b0, 32'h1});
        idle(1);
        for (int k = 0; k < 6; k++) begin
            ch  = (k % 2) + 1;
            raw = (k == 3) ? 10'h0 : 10'($urandom());
            req(1'b1, AIS_OBJ_OFFSET, 8'(ch), offs[k], {1'b0, 32'h0});
            req(1'b1, AIS_OBJ_DIVISOR, 8'(ch), divs[k], {1'b0, 32'h0});
            req(1'b0, AIS_OBJ_DIVISOR, 8'(ch), 32'h0, {1'b0, divs[k]});
            idle(1);
            ais_adc_model_inst.send(ch, raw);
            idle(40);
            req(1'b0, AIS_OBJ_VALUE, 8'(ch), 32'h0, {1'b0, scale(raw, offs[k], divs[k])});
            idle(1);
        end
        i_rst = 1'b1;
        repeat (2) @(posedge i_core_clk);
        #1;
        i_rst = 1'b0;
        req(1'b0, AIS_OBJ_OFFSET, AIS_SUB_CH1, 32'h0, {1'b0, 32'h0});
        idle(3);
        cmp_obj({1'b0, 32'(exp_q.size())}, 33'h0);
        close_out();
    end
endmodule
